// ===== rtl/adcro_readout.sv
/*
 * Serial result readout port: busy flag, result register and the shift
 * logic that runs on the host's serial clock.
 * A frame is sixteen bits: four leading zeros, then the twelve result bits,
 * most significant first. The first zero appears on the first rising edge,
 * every further bit changes on a falling edge, and the pin is released after
 * the sixteenth falling edge unless more pulses follow.
 * A falling start edge begins a conversion and, with the serial clock low,
 * also resets the frame so that the next read begins at its first zero.
 * Assumes the host is master, parks serial_clock low between reads, and
 * that conversion_result is valid on mclk whenever a conversion completes.
 * Assumes reset is held for at least two mclk edges and rises cleanly, since
 * it also clears the serial clock flops asynchronously.
 */
`timescale 1ns/1ps
module adcro_readout #(
    parameter int CONV_CYCLES = adcro_pkg::CONV_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        serial_clock,
    input  wire logic        conversion_start_n,
    input  wire logic [11:0] conversion_result,
    output logic             serial_data_out,
    output logic             serial_data_oe_n,
    output logic             conversion_busy
);

    ////////////////////////////////////////////////////////////////////////////
    // System clock side.
    ////////////////////////////////////////////////////////////////////////////

    logic [1:0]  pins_sync;     // Synchronised start and serial clock levels.
    logic        start_level;   // Start pin after two flops.
    logic        sclk_level;    // Serial clock pin after two flops.
    logic        start_prev;    // Start level one cycle earlier.
    logic        start_fall;    // One-cycle pulse on a start falling edge.
    logic        conv_done;     // One-cycle pulse when the result is ready.
    logic [11:0] result_word;   // Held result, quasi-static for the link side.
    logic        req_tog;       // Flips to ask the link side for a fresh frame.

    // Both pins come from outside the mclk domain.
    adcro_sync #(
        .WIDTH (2),
        .INIT  (2'b01)
    ) u_pin_sync (
        .mclk     (mclk),
        .reset    (reset),
        .async_in ({serial_clock, conversion_start_n}),
        .sync_out (pins_sync)
    );

    assign start_level = pins_sync[0];
    assign sclk_level  = pins_sync[1];

    // Start is idle high, so resetting the history high avoids a false edge.
    always_ff @(posedge mclk) begin
        if (reset) begin
            start_prev <= 1'b1;
        end else begin
            start_prev <= start_level;
        end
    end

    assign start_fall = start_prev & ~start_level;

    // Conversion sequencer drives the busy pin directly.
    adcro_conv_timer #(
        .CYCLES (CONV_CYCLES)
    ) u_conv_timer (
        .mclk        (mclk),
        .reset       (reset),
        .start_pulse (start_fall),
        .busy        (conversion_busy),
        .done_pulse  (conv_done)
    );

    // The new result lands in the output register as busy drops.
    always_ff @(posedge mclk) begin
        if (reset) begin
            result_word <= adcro_pkg::RESULT_RESET;
        end else if (conv_done) begin
            result_word <= conversion_result;
        end
    end

    // A start edge seen while the serial clock rests low resets the frame.
    // With the clock high the reset is skipped and the frame carries on.
    always_ff @(posedge mclk) begin
        if (reset) begin
            req_tog <= 1'b0;
        end else if (start_fall && !sclk_level) begin
            req_tog <= ~req_tog;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial clock side.
    ////////////////////////////////////////////////////////////////////////////

    // The serial clock stands still between frames, so no synchroniser can be
    // clocked there. Instead req_tog only changes while the clock rests low and
    // result_word only on a completed conversion; the link flops sample them at the next edge: a toggle
    // handshake whose acknowledge is ack_tog.
    //
    // Walk of one frame, counting edges of the serial clock:
    //   before rise 1 : pin released, frame reset pending (fresh).
    //   rise 1        : pin driven, first leading zero shown.
    //   fall 1        : request taken, bit 1 shown, count one.
    //   fall k        : bit k shown, count k, for k up to fifteen.
    //   fall 16       : done set, pin released.
    //   rise 17 on    : frame starts over at its first zero, pin kept driven.
    // A pause anywhere leaves count and register untouched.

    logic [15:0]                      shreg;     // Output shift register.
    logic [adcro_pkg::FALL_CNT_W-1:0] fall_cnt;  // Falling edges in this frame.
    logic                             ack_tog;   // Frame request taken.
    logic                             done;      // Sixteen falls seen.
    logic                             keep;      // Extra pulses: never release.
    logic                             rise_tog;  // Request seen at a rising edge.
    logic                             rose;      // Any rising edge since reset.
    logic                             extra;     // A rise came after the sixteenth fall.
    logic                             fresh;     // Frame reset, no fall yet.
    logic                             drive;     // Pin driven this moment.
    logic [15:0]                      frame_word; // Four zeros, then result.

    localparam logic [adcro_pkg::FALL_CNT_W-1:0] FALL_ONE  =
        adcro_pkg::FALL_CNT_W'(1);
    localparam logic [adcro_pkg::FALL_CNT_W-1:0] FALL_LSB  =
        adcro_pkg::FALL_CNT_W'(adcro_pkg::FRAME_BITS - 1);
    localparam logic [adcro_pkg::FALL_CNT_W-1:0] FALL_LAST =
        adcro_pkg::FALL_CNT_W'(adcro_pkg::FRAME_BITS);
    // Counts below this still show a leading zero.
    localparam logic [adcro_pkg::FALL_CNT_W-1:0] FALL_LEAD =
        adcro_pkg::FALL_CNT_W'(adcro_pkg::LEAD_ZEROS);

    assign frame_word = {{adcro_pkg::LEAD_ZEROS{1'b0}}, result_word};
    assign fresh      = (req_tog != ack_tog);

    // Falling edges move the frame on one bit; the count marks where the frame ends.
    always_ff @(negedge serial_clock or posedge reset) begin
        if (reset) begin
            shreg    <= adcro_pkg::FRAME_RESET;
            fall_cnt <= '0;
            ack_tog  <= 1'b0;
            done     <= 1'b0;
            keep     <= 1'b0;
        end else if (fresh) begin
            // First fall of a new frame: bit 0 already shown, move to bit 1.
            shreg    <= {frame_word[14:0], 1'b0};
            fall_cnt <= FALL_ONE;
            ack_tog  <= req_tog;
            done     <= 1'b0;
            keep     <= 1'b0;
        end else if (fall_cnt == FALL_LAST) begin
            // Pulses past the sixteenth start the register over, held driven.
            shreg    <= {frame_word[14:0], 1'b0};
            fall_cnt <= FALL_ONE;
            done     <= 1'b0;
            keep     <= 1'b1;
        end else begin
            // A paused clock simply leaves this state where it was.
            shreg    <= {shreg[14:0], 1'b0};
            fall_cnt <= fall_cnt + 1'b1;
            done     <= (fall_cnt == FALL_LSB);
        end
    end

    // A rising edge marks that the current frame has begun on the pin.
    always_ff @(posedge serial_clock or posedge reset) begin
        if (reset) begin
            rise_tog <= 1'b0;
            rose     <= 1'b0;
        end else begin
            rise_tog <= req_tog;
            rose     <= 1'b1;
        end
    end

    // A rise after the sixteenth fall restarts the frame at its first zero,
    // which the emptied shift register already shows; the pin is driven again
    // at once so the host samples a real bit in that high phase.
    always_ff @(posedge serial_clock or posedge reset) begin
        if (reset) begin
            extra <= 1'b0;
        end else if (rise_tog != req_tog) begin
            // First rise of a new frame: no extra pulses yet.
            extra <= 1'b0;
        end else if (done) begin
            // Pulse past the frame: keep the pin driven from here on.
            extra <= 1'b1;
        end
    end

    // Released after reset or a frame reset until the first rising edge, and
    // after the sixteenth fall unless extra pulses have been seen.
    // The extra term covers the high phase of the first pulse past the frame.
    assign drive = rose && (rise_tog == req_tog)
                   && (fresh || !done || keep || extra);

    assign serial_data_oe_n = ~drive;

    // Before the first fall the pin shows the first leading zero.
    assign serial_data_out = fresh ? 1'b0 : shreg[15];

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    ////////////////////////////////////////////////////////////////////////////

    localparam int CONV_MAX = CONV_CYCLES + 1;

    // A start edge makes busy rise on the next cycle.
    busy_rise_a: assert property (@(posedge mclk) disable iff (reset)
        start_fall |=> conversion_busy)
        else $error("busy did not rise after start edge");

    // Busy ends within the conversion time.
    busy_end_a: assert property (@(posedge mclk) disable iff (reset)
        $rose(conversion_busy) |-> ##[1:CONV_MAX] !conversion_busy)
        else $error("busy held past the conversion time");

    // The held result is the one present when busy dropped.
    result_load_a: assert property (@(posedge mclk) disable iff (reset)
        (conversion_busy && !start_fall) ##1 !conversion_busy
        |-> result_word == $past(conversion_result))
        else $error("result not loaded when busy fell");

    // Start edge with the clock low resets the frame; with it high it does not.
    frame_reset_a: assert property (@(posedge mclk) disable iff (reset)
        start_fall |=> (req_tog != $past(req_tog)) == !$past(sclk_level))
        else $error("frame reset does not follow clock level");

    // First bit of a frame is a driven zero before the first fall.
    first_zero_a: assert property (@(negedge serial_clock) disable iff (reset)
        (fresh && rose && rise_tog == req_tog) |-> (!serial_data_oe_n && !serial_data_out))
        else $error("first leading zero not driven");

    // Leading zeros fill falls one to three.
    lead_zero_a: assert property (@(negedge serial_clock) disable iff (reset)
        (!fresh && fall_cnt < FALL_LEAD) |-> !serial_data_out)
        else $error("leading zero missing");

    // Bit after fifteen falls is the least significant result bit.
    lsb_bit_a: assert property (@(negedge serial_clock) disable iff (reset)
        (!fresh && fall_cnt == FALL_LSB) |-> serial_data_out == result_word[0])
        else $error("least significant bit misplaced");

    // The pin stays released from the sixteenth fall up to the next rise.
    release_a: assert property (@(posedge serial_clock) disable iff (reset)
        (done && !keep) |-> serial_data_oe_n)
        else $error("pin not released after sixteenth fall");

    // Extra pulses keep the pin driven.
    restart_drive_a: assert property (@(negedge serial_clock) disable iff (reset)
        (!fresh && keep && rise_tog == req_tog) |-> !serial_data_oe_n)
        else $error("pin released after restart");

    // Edge count never passes a full frame.
    count_range_a: assert property (@(negedge serial_clock) disable iff (reset)
        fall_cnt <= FALL_LAST)
        else $error("edge counter out of range");

    // Before the first serial clock rise since reset the pin stays released.
    pin_idle_a: assert property (@(posedge mclk) disable iff (reset)
        !rose |-> serial_data_oe_n)
        else $error("pin driven before any rising edge");

    // A frame reset releases the pin at once, without any serial clock edge.
    fresh_release_a: assert property (@(posedge mclk) disable iff (reset)
        (start_fall && !sclk_level) |=> serial_data_oe_n)
        else $error("pin driven after frame reset");

    // The held result only changes with a completed conversion.
    result_hold_a: assert property (@(posedge mclk) disable iff (reset)
        !conv_done |=> $stable(result_word))
        else $error("result changed without a conversion");

    // The completion pulse drops busy on the edge that loads the result.
    done_busy_a: assert property (@(posedge mclk) disable iff (reset)
        conv_done |=> !conversion_busy)
        else $error("busy still high after completion");

    // Main scenarios: full frame, restart, conversion, skipped reset, extra rise.
    full_frame_c: cover property (@(negedge serial_clock) disable iff (reset)
        !fresh && fall_cnt == FALL_LSB);
    restart_c: cover property (@(negedge serial_clock) disable iff (reset)
        keep && fall_cnt == FALL_ONE);
    conv_done_c: cover property (@(posedge mclk) disable iff (reset)
        $fell(conversion_busy));
    skip_reset_c: cover property (@(posedge mclk) disable iff (reset)
        start_fall && sclk_level);
    extra_rise_c: cover property (@(posedge serial_clock) disable iff (reset)
        done && !keep);

endmodule : adcro_readout

// ===== pkg/adcro_pkg.sv
/*
 * Constants shared by the serial result readout port of the 12-bit converter.
 * Assumes the system clock mclk runs at 10 MHz and the host owns the serial clock.
 */
package adcro_pkg;

    // Frame layout.
    localparam int RESULT_BITS = 12;
    localparam int LEAD_ZEROS  = 4;
    localparam int FRAME_BITS  = RESULT_BITS + LEAD_ZEROS;
    localparam int FALL_CNT_W  = 5;

    // Reset values.
    localparam logic [11:0] RESULT_RESET = 12'h000;
    localparam logic [15:0] FRAME_RESET  = 16'h0000;

    // Conversion timing: the longest time rounds down to whole cycles.
    localparam int MCLK_PERIOD_PS = 100_000;
    localparam int CONV_TIME_PS   = 3_800_000;
    localparam int CONV_CYCLES_RAW = CONV_TIME_PS / MCLK_PERIOD_PS;
    localparam int CONV_CYCLES    = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
    localparam int CONV_CNT_W     = 8;

    // Conversion sequencer states.
    typedef enum logic [0:0] {
        ADCRO_IDLE       = 1'b0,
        ADCRO_CONVERTING = 1'b1
    } adcro_conv_state_t;

endpackage : adcro_pkg

// ===== rtl/adcro_sync.sv
/*
 * Two flip-flop synchroniser for a group of independent levels.
 * Assumes each bit is a level that stays put for several mclk periods.
 */
`timescale 1ns/1ps
module adcro_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;   // First stage, read only by the second stage.

    // Two stages; only the second is visible outside.
    always_ff @(posedge mclk) begin
        if (reset) begin
            stage1   <= INIT;
            sync_out <= INIT;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : adcro_sync

// ===== rtl/adcro_conv_timer.sv
/*
 * Conversion sequencer: busy for a fixed count after each start pulse.
 * Assumes start_pulse is a one-cycle pulse on mclk.
 */
`timescale 1ns/1ps
module adcro_conv_timer #(
    parameter int CYCLES = adcro_pkg::CONV_CYCLES
) (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic start_pulse,
    output logic      busy,
    output logic      done_pulse
);

    adcro_pkg::adcro_conv_state_t state;             // Sequencer state.
    logic [adcro_pkg::CONV_CNT_W-1:0] count;         // Cycles spent converting.
    localparam logic [adcro_pkg::CONV_CNT_W-1:0] LAST =
        adcro_pkg::CONV_CNT_W'(CYCLES - 1);

    // A start restarts the count even mid conversion; the track/hold re-samples.
    always_ff @(posedge mclk) begin
        if (reset) begin
            state      <= adcro_pkg::ADCRO_IDLE;
            count      <= '0;
        end else begin
            if (start_pulse) begin
                state <= adcro_pkg::ADCRO_CONVERTING;
                count <= '0;
            end else begin
                unique case (state)
                    adcro_pkg::ADCRO_IDLE: begin
                        count <= '0;
                    end
                    adcro_pkg::ADCRO_CONVERTING: begin
                        // Finish exactly CYCLES cycles after the start.
                        if (count == LAST) begin
                            state      <= adcro_pkg::ADCRO_IDLE;
                        end else begin
                            count <= count + 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // Busy is a pure decode of the state register.
    assign busy = (state == adcro_pkg::ADCRO_CONVERTING);

    // Completion is flagged on the edge that drops busy, so the result register
    // loads on that same edge and is never stale while busy is already low.
    assign done_pulse = busy && (count == LAST) && !start_pulse;

endmodule : adcro_conv_timer

// ===== tb/adcro_host_model.sv
/*
 * Host model for the serial result readout port: it is the link master.
 * Assumes the bench calls its tasks one at a time and feeds it the resolved pin.
 */
`timescale 1ns/1ps
module adcro_host_model (
    input  wire logic mclk,
    input  wire logic serial_data_out_pin,
    input  wire logic conversion_busy,
    output logic      serial_clock,
    output logic      conversion_start_n
);
    ////////////////////////////////////////////////////////////////////////////
    logic link_clk;     // Raw serial clock of the host port.
    logic port_select;  // Select line that gates the clock onto this converter.

    // The host makes the clock and gates it with a select line.
    assign serial_clock = link_clk & port_select;

    // The link clock stands low outside frames.
    initial begin
        link_clk = 1'b0;
        port_select = 1'b1;
        conversion_start_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Gives n pulses of 48 ns, sampling each bit late in the high phase.
    task automatic read_bits(input int n, output logic [15:0] word);
        word = 16'h0000;
        for (int i = 0; i < n; i++) begin
            #11;
            link_clk = 1'b1;
            #24;
            word = {word[14:0], serial_data_out_pin};
            link_clk = 1'b0;
            #13;
        end
    endtask : read_bits

    // Opens or closes the gate between the port clock and this converter.
    task automatic set_select(input logic sel);
        port_select = sel;
    endtask : set_select

    // Pulses the start pin and counts the cycles busy is seen high.
    task automatic start_conv(input logic clk_level, output int hi_cycles, output bit ok);
        hi_cycles = 0;
        ok = 1'b0;
        link_clk = clk_level;
        repeat (4) @(posedge mclk);
        conversion_start_n <= 1'b0;
        for (int c = 0; c < 1000 && !ok; c++) begin
            @(posedge mclk);
            if (c == 4) begin
                conversion_start_n <= 1'b1;
            end
            if (conversion_busy === 1'b1) begin
                hi_cycles++;
            end else if (hi_cycles > 0) begin
                ok = 1'b1;
            end
        end
        link_clk = 1'b0;
    endtask : start_conv
endmodule : adcro_host_model

// ===== tb/adc_serial_result_readout_tb.sv
/*
 * Self-checking bench for the serial result readout port.
 * Assumes the host model drives the link and the bench drives mclk and the result.
 */
`timescale 1ns/1ps
module adc_serial_result_readout_tb;
    localparam int CONV = 6;  // Shortened conversion count.

    logic        mclk;               // System clock.
    logic        reset;              // Synchronous reset.
    logic [11:0] conversion_result;  // Result offered by the engine.
    logic        serial_clock;       // Link clock from the host.
    logic        conversion_start_n; // Start pin from the host.
    logic        serial_data_out;    // Data from the port.
    logic        serial_data_oe_n;   // Active-low enable of the data pin.
    logic        conversion_busy;    // Busy flag.
    logic        last_bit = 1'b0;    // Last level driven on the pin.
    logic        serial_data_out_pin;          // Resolved pin level.
    int          n_fail;             // Mismatches seen.
    int          tests_run;          // Comparisons made.

    ////////////////////////////////////////////////////////////////////////////
    // A released pin shows the inverse of its last level, never a stale copy.
    always @(serial_data_out or serial_data_oe_n) begin
        if (serial_data_oe_n === 1'b0) begin
            last_bit = serial_data_out;
        end
    end
    assign serial_data_out_pin = (serial_data_oe_n === 1'b0) ? serial_data_out : ~last_bit;

    // The system clock inverts every half period.
    always #50 mclk = ~mclk;

    adcro_readout #(.CONV_CYCLES(CONV)) uut (
        .mclk              (mclk),
        .reset             (reset),
        .serial_clock      (serial_clock),
        .conversion_start_n(conversion_start_n),
        .conversion_result (conversion_result),
        .serial_data_out   (serial_data_out),
        .serial_data_oe_n  (serial_data_oe_n),
        .conversion_busy   (conversion_busy)
    );

    adcro_host_model host (
        .mclk              (mclk),
        .serial_data_out_pin         (serial_data_out_pin),
        .conversion_busy   (conversion_busy),
        .serial_clock      (serial_clock),
        .conversion_start_n(conversion_start_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // Compares a received word.
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    // Compares a single flag.
    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_bit

    // Runs one conversion and checks the busy length; a hang ends the run.
    task automatic do_conv(input logic [11:0] value, input logic clk_level);
        int hi;
        bit ok;
        @(posedge mclk);
        conversion_result <= value;
        host.start_conv(clk_level, hi, ok);
        if (!ok) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
            tally_and_finish();
        end else begin
            check_word(16'(hi), 16'(CONV));
        end
    endtask : do_conv

    ////////////////////////////////////////////////////////////////////////////
    // A read straight after reset shows the all-zero frame.
    task automatic reset_read();
        logic [15:0] w;
        check_bit(serial_data_oe_n, 1'b1);
        host.read_bits(16, w);
        check_word(w, 16'h0000);
        check_bit(serial_data_oe_n, 1'b1);
    endtask : reset_read

    // A full frame after a conversion.
    task automatic full_read();
        logic [15:0] w;
        do_conv(12'hA5C, 1'b0);
        check_bit(serial_data_oe_n, 1'b1);
        host.read_bits(16, w);
        check_word(w, 16'h0A5C);
        check_bit(serial_data_oe_n, 1'b1);
    endtask : full_read

    // A frame read as two bytes with a pause between.
    task automatic paused_read();
        logic [15:0] w1;
        logic [15:0] w2;
        do_conv(12'h5A3, 1'b0);
        host.read_bits(8, w1);
        repeat (10) @(posedge mclk);
        // Pulses with the select low must not reach the port.
        host.set_select(1'b0);
        host.read_bits(4, w2);
        host.set_select(1'b1);
        host.read_bits(8, w2);
        check_word({w1[7:0], w2[7:0]}, 16'h05A3);
    endtask : paused_read

    // Extra pulses restart the frame and keep the pin driven.
    task automatic extra_pulses();
        logic [15:0] w;
        do_conv(12'hC37, 1'b0);
        host.read_bits(16, w);
        host.read_bits(6, w);
        check_word(w, 16'h0003);
        repeat (5) @(posedge mclk);
        check_bit(serial_data_oe_n, 1'b0);
        do_conv(12'h0F0, 1'b0);
        check_bit(serial_data_oe_n, 1'b1);
        host.read_bits(16, w);
        check_word(w, 16'h00F0);
    endtask : extra_pulses

    // A start with the clock high must not reset the frame.
    task automatic start_clock_high();
        logic [15:0] w;
        do_conv(12'h111, 1'b0);
        host.read_bits(5, w);
        do_conv(12'h222, 1'b1);
        check_bit(serial_data_oe_n, 1'b0);
        do_conv(12'hFFF, 1'b0);
        check_bit(serial_data_oe_n, 1'b1);
        host.read_bits(16, w);
        check_word(w, 16'h0FFF);
    endtask : start_clock_high

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset for 8 cycles, then every scenario in turn.
    initial begin
        mclk = 1'b0;
        reset = 1'b0;
        conversion_result = 12'h000;
        n_fail = 0;
        tests_run = 0;
        // Reset rises on the first edge so the link flops see a clean rising edge.
        @(posedge mclk);
        reset <= 1'b1;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_read();
        full_read();
        paused_read();
        extra_pulses();
        start_clock_high();
        tally_and_finish();
    end
endmodule : adc_serial_result_readout_tb
